// *** bridge_cfg_pkg.sv ***
// Shared constants, carrier types and decode helpers for the bridge configuration header
`default_nettype none
package bridge_cfg_pkg;

    // Byte offsets of the header fields within configuration space
    localparam logic [7:0] OFF_PRI_STATUS = 8'h06;
    localparam logic [7:0] OFF_REVISION = 8'h08;
    localparam logic [7:0] OFF_CLASS = 8'h09;
    localparam logic [7:0] OFF_CACHELINE = 8'h0C;
    localparam logic [7:0] OFF_PRI_LATENCY = 8'h0D;
    localparam logic [7:0] OFF_HEADER = 8'h0E;
    localparam logic [7:0] OFF_PRI_BUS = 8'h18;
    localparam logic [7:0] OFF_SEC_BUS = 8'h19;
    localparam logic [7:0] OFF_SUB_BUS = 8'h1A;
    localparam logic [7:0] OFF_IO_BASE = 8'h1C;
    localparam logic [7:0] OFF_IO_LIMIT = 8'h1D;
    localparam logic [7:0] OFF_SEC_STATUS = 8'h1E;
    localparam logic [7:0] OFF_SUBSYS_VENDOR = 8'h2C;
    localparam logic [7:0] OFF_SUBSYS_IDENT = 8'h2E;
    localparam logic [7:0] OFF_CAP_POINTER = 8'h34;
    localparam logic [7:0] OFF_INT_LINE = 8'h3C;
    localparam logic [7:0] OFF_INT_PIN = 8'h3D;

    // Field positions
    localparam int CAP_LIST_BIT = 4;
    localparam int SEC_PARITY_BIT = 15;
    localparam int SEC_SYS_ERR_BIT = 14;
    localparam int SEC_MASTER_ABORT_BIT = 13;
    localparam int SEC_TARGET_ABORT_RX_BIT = 12;
    localparam int SEC_TARGET_ABORT_TX_BIT = 11;
    localparam int SEC_DATA_PARITY_BIT = 8;

    // Fixed identification values
    localparam logic [7:0] BASE_CLASS_BRIDGE = 8'h06;
    localparam logic [7:0] SUB_CLASS_HOST = 8'h00;
    localparam logic [7:0] SUB_CLASS_P2P = 8'h04;
    localparam logic [7:0] PROG_IF_NONE = 8'h00;
    localparam logic [6:0] LAYOUT_TYPE0 = 7'h00;
    localparam logic [6:0] LAYOUT_TYPE1 = 7'h01;
    localparam logic [1:0] IO_ADDR_CAP_16BIT = 2'h0;

    // Reset values
    localparam logic [7:0] CACHELINE_RST = 8'h00;
    localparam logic [7:0] BUS_NUMBER_RST = 8'h00;
    localparam logic [5:0] IO_WINDOW_RST = 6'h00;
    localparam logic [15:0] SUBSYS_IDENT_RST = 16'h0000;
    localparam logic [7:0] CAP_POINTER_RST = 8'h40;
    localparam logic [7:0] INT_LINE_RST = 8'h00;
    localparam logic [7:0] INT_PIN_RST = 8'h01;
    localparam logic [5:0] SEC_STATUS_RST = 6'h00;

    // Legacy interrupt pin codes
    localparam logic [7:0] INT_PIN_A = 8'h01;
    localparam logic [7:0] INT_PIN_B = 8'h02;
    localparam logic [7:0] INT_PIN_C = 8'h03;
    localparam logic [7:0] INT_PIN_D = 8'h04;

    // Configuration access: dword index into the 64-byte header
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] dw;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_s;

    // Secondary-side error events, one-cycle pulses
    typedef struct packed {
        logic poisoned_tlp_rx;
        logic err_msg_rx;
        logic ur_cpl_rx;
        logic type0_abort;
        logic ca_cpl_rx;
        logic ca_cpl_sent;
        logic poisoned_cpl_rx;
        logic poisoned_tx;
    } sec_evt_s;

    // Inbound configuration request routing query
    typedef struct packed {
        logic valid;
        logic [7:0] bus;
    } bus_query_s;

    // Downstream I/O request query
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } io_query_s;

    // Dword index of a byte offset
    function automatic logic [3:0] dw_of(input logic [7:0] off);
        dw_of = off[5:2];
    endfunction : dw_of

    // Byte lane of a byte offset
    function automatic logic [1:0] lane_of(input logic [7:0] off);
        lane_of = off[1:0];
    endfunction : lane_of

endpackage : bridge_cfg_pkg
`default_nettype wire

// *** write_once_field.sv ***
// Field that takes one software write after reset and then reads only
`timescale 1ns/10ps
`default_nettype none
module write_once_field #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Write strobe with per-bit lane mask
    input wire logic wr,
    input wire logic [W-1:0] wmask,
    input wire logic [W-1:0] wdata,
    // Stored value
    output logic [W-1:0] value_q
);
    logic written_q;

    // First write updates enabled lanes and locks the field until reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            written_q <= 1'b0;
            value_q <= RST;
        end else if (wr && !written_q) begin
            written_q <= 1'b1;
            value_q <= (value_q & ~wmask) | (wdata & wmask);
        end
    end
endmodule : write_once_field
`default_nettype wire

// *** bridge_config_header.sv ***
// Configuration header for the host-link function or a root-port virtual bridge
//
// What this block does
// - Primary status reports capability list present
// - Revision nibbles: full-mask and metal steppings, write-once
// - Base class 06h, interface 00h, host-link subclass 00h
// - Root port subclass 04h, 00h in host mode
// - Cacheline size stored but never used
// - Legacy timing and capability fields read zero
// - Single-function; layout type 0 or type 1
// - Subsystem vendor and identity written once
// - Capability pointer defaults 40h, write-once
// - Interrupt pin defaults 01h, write-once, codes A-D
// - Primary bus number steers inbound decode
// - Forward config when secondary <= bus <= subordinate
// - Forward I/O when base <= A[15:12] <= limit
// - One-KB granularity opens bits 3:2 for decode
// - Limit below base forwards no I/O
// - I/O capability bits read 0h, 16-bit only
// - Poisoned TLP sets status bit 15 always
// - Fatal or nonfatal message sets bit 14
// - UR completion or type0 abort sets 13
// - CA received sets 12; CA sent sets 11
// - Bit 8 only with parity response enabled
`timescale 1ns/10ps
`default_nettype none
module bridge_config_header #(
    parameter bit IS_ROOT_PORT = 1'b1,
    // Arbitrary neutral values; real ones are loaded by firmware
    parameter logic [3:0] FULL_MASK_STEP_RST = 4'h0,
    parameter logic [3:0] METAL_STEP_RST = 4'h0,
    parameter logic [15:0] SUBSYS_VENDOR_RST = 16'h1234
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Configuration access
    input wire bridge_cfg_pkg::cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata_q,
    output logic cfg_rvalid_q,
    // Control levels from neighbouring registers
    input wire logic host_bridge_mode,
    input wire logic one_kb_io_granularity,
    input wire logic parity_error_response_enable,
    input wire logic io_decode_enable,
    // Secondary-side error events
    input wire bridge_cfg_pkg::sec_evt_s sec_evt,
    // Routing queries
    input wire bridge_cfg_pkg::bus_query_s bus_query,
    input wire bridge_cfg_pkg::io_query_s io_query,
    // Routing answers
    output logic primary_bus_hit_q,
    output logic fwd_cfg_q,
    output logic fwd_io_q,
    // Interrupt routing
    output logic [3:0] legacy_interrupt_select_q
);
    import bridge_cfg_pkg::*;

    // Storage
    logic [7:0] cacheline_q;
    logic [7:0] pri_bus_q;
    logic [7:0] sec_bus_q;
    logic [7:0] sub_bus_q;
    logic [5:0] io_base_q;
    logic [5:0] io_limit_q;
    logic [5:0] sec_sts_q;
    logic [5:0] sec_sts_d;
    logic [7:0] int_line_q;
    logic [3:0] full_step;
    logic [3:0] metal_step;
    logic [15:0] subsys_vendor;
    logic [15:0] subsys_ident;
    logic [7:0] cap_pointer;
    logic [7:0] int_pin;

    // True when this access writes the byte at the given offset
    function automatic logic byte_wr(input cfg_req_s r, input logic [7:0] off);
        byte_wr = r.wr && (r.dw == dw_of(off)) && r.be[lane_of(off)];
    endfunction : byte_wr

    // Write data byte for the given offset
    function automatic logic [7:0] byte_data(input cfg_req_s r, input logic [7:0] off);
        byte_data = r.wdata[{lane_of(off), 3'b000} +: 8];
    endfunction : byte_data

    // Per-byte write strobes
    wire wr_revision = byte_wr(cfg_req, OFF_REVISION);
    wire wr_cacheline = byte_wr(cfg_req, OFF_CACHELINE);
    wire wr_pri_bus = byte_wr(cfg_req, OFF_PRI_BUS);
    wire wr_sec_bus = IS_ROOT_PORT && byte_wr(cfg_req, OFF_SEC_BUS);
    wire wr_sub_bus = IS_ROOT_PORT && byte_wr(cfg_req, OFF_SUB_BUS);
    wire wr_io_base = IS_ROOT_PORT && byte_wr(cfg_req, OFF_IO_BASE);
    wire wr_io_limit = IS_ROOT_PORT && byte_wr(cfg_req, OFF_IO_LIMIT);
    wire wr_sts_lo = IS_ROOT_PORT && byte_wr(cfg_req, OFF_SEC_STATUS);
    wire wr_sts_hi = IS_ROOT_PORT && byte_wr(cfg_req, 8'(OFF_SEC_STATUS + 8'h01));
    wire wr_subsystem_vendor_lo = byte_wr(cfg_req, OFF_SUBSYS_VENDOR);
    wire wr_subsystem_vendor_hi = byte_wr(cfg_req, 8'(OFF_SUBSYS_VENDOR + 8'h01));
    wire wr_sid_lo = byte_wr(cfg_req, OFF_SUBSYS_IDENT);
    wire wr_sid_hi = byte_wr(cfg_req, 8'(OFF_SUBSYS_IDENT + 8'h01));
    wire wr_cap_pointer = byte_wr(cfg_req, OFF_CAP_POINTER);
    wire wr_int_line = byte_wr(cfg_req, OFF_INT_LINE);
    wire wr_int_pin = byte_wr(cfg_req, OFF_INT_PIN);

    // Write data bytes
    wire [7:0] wd_revision = byte_data(cfg_req, OFF_REVISION);
    wire [7:0] wd_io_base = byte_data(cfg_req, OFF_IO_BASE);
    wire [7:0] wd_io_limit = byte_data(cfg_req, OFF_IO_LIMIT);
    wire [15:0] wd_subsystem_vendor = cfg_req.wdata[15:0];
    wire [15:0] wd_sid = cfg_req.wdata[31:16];

    // Stepping nibbles each carry their own lock
    write_once_field #(.W(4), .RST(FULL_MASK_STEP_RST)) u_full_step (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_revision),
        .wmask(4'hF),
        .wdata(wd_revision[7:4]),
        .value_q(full_step)
    );

    write_once_field #(.W(4), .RST(METAL_STEP_RST)) u_metal_step (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_revision),
        .wmask(4'hF),
        .wdata(wd_revision[3:0]),
        .value_q(metal_step)
    );

    // A write to either byte of the field spends its single write
    write_once_field #(.W(16), .RST(SUBSYS_VENDOR_RST)) u_subsys_vendor (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_subsystem_vendor_lo || wr_subsystem_vendor_hi),
        .wmask({{8{wr_subsystem_vendor_hi}}, {8{wr_subsystem_vendor_lo}}}),
        .wdata(wd_subsystem_vendor),
        .value_q(subsys_vendor)
    );

    write_once_field #(.W(16), .RST(SUBSYS_IDENT_RST)) u_subsys_ident (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_sid_lo || wr_sid_hi),
        .wmask({{8{wr_sid_hi}}, {8{wr_sid_lo}}}),
        .wdata(wd_sid),
        .value_q(subsys_ident)
    );

    write_once_field #(.W(8), .RST(CAP_POINTER_RST)) u_cap_pointer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_cap_pointer),
        .wmask(8'hFF),
        .wdata(byte_data(cfg_req, OFF_CAP_POINTER)),
        .value_q(cap_pointer)
    );

    write_once_field #(.W(8), .RST(INT_PIN_RST)) u_int_pin (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(wr_int_pin),
        .wmask(8'hFF),
        .wdata(byte_data(cfg_req, OFF_INT_PIN)),
        .value_q(int_pin)
    );

    // Plain read/write bytes; cacheline size is stored only, lines stay 64 bytes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cacheline_q <= CACHELINE_RST;
            pri_bus_q <= BUS_NUMBER_RST;
            sec_bus_q <= BUS_NUMBER_RST;
            sub_bus_q <= BUS_NUMBER_RST;
            int_line_q <= INT_LINE_RST;
        end else begin
            if (wr_cacheline) cacheline_q <= byte_data(cfg_req, OFF_CACHELINE);
            if (wr_pri_bus) pri_bus_q <= byte_data(cfg_req, OFF_PRI_BUS);
            if (wr_sec_bus) sec_bus_q <= byte_data(cfg_req, OFF_SEC_BUS);
            if (wr_sub_bus) sub_bus_q <= byte_data(cfg_req, OFF_SUB_BUS);
            if (wr_int_line) int_line_q <= byte_data(cfg_req, OFF_INT_LINE);
        end
    end

    // Window bytes hold bits 7:2; bits 3:2 open only under 1 KB granularity
    wire [5:0] io_base_d = {wd_io_base[7:4],
        one_kb_io_granularity ? wd_io_base[3:2] : io_base_q[1:0]};
    wire [5:0] io_limit_d = {wd_io_limit[7:4],
        one_kb_io_granularity ? wd_io_limit[3:2] : io_limit_q[1:0]};

    // Window registers; software is expected to drop decode while changing them
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            io_base_q <= IO_WINDOW_RST;
            io_limit_q <= IO_WINDOW_RST;
        end else begin
            if (wr_io_base) io_base_q <= io_base_d;
            if (wr_io_limit) io_limit_q <= io_limit_d;
        end
    end

    // Secondary-side events; bit 8 needs parity error response enabled
    wire [5:0] sts_set = IS_ROOT_PORT ? {
        sec_evt.poisoned_tlp_rx,
        sec_evt.err_msg_rx,
        sec_evt.ur_cpl_rx | sec_evt.type0_abort,
        sec_evt.ca_cpl_rx,
        sec_evt.ca_cpl_sent,
        parity_error_response_enable & (sec_evt.poisoned_cpl_rx | sec_evt.poisoned_tx)
    } : 6'h00;

    // Write-one-to-clear mask aligned to the stored bits
    wire [5:0] sts_clr = {
        wr_sts_hi & cfg_req.wdata[16 + SEC_PARITY_BIT],
        wr_sts_hi & cfg_req.wdata[16 + SEC_SYS_ERR_BIT],
        wr_sts_hi & cfg_req.wdata[16 + SEC_MASTER_ABORT_BIT],
        wr_sts_hi & cfg_req.wdata[16 + SEC_TARGET_ABORT_RX_BIT],
        wr_sts_hi & cfg_req.wdata[16 + SEC_TARGET_ABORT_TX_BIT],
        wr_sts_hi & cfg_req.wdata[16 + SEC_DATA_PARITY_BIT]
    };

    // Set beats clear so an event in the clearing cycle survives
    assign sec_sts_d = (sec_sts_q & ~sts_clr) | sts_set;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sec_sts_q <= SEC_STATUS_RST;
        end else begin
            sec_sts_q <= sec_sts_d;
        end
    end

    // Read views of composite fields
    wire [7:0] sub_class = (IS_ROOT_PORT && !host_bridge_mode) ? SUB_CLASS_P2P
        : SUB_CLASS_HOST;
    wire [23:0] class_code = {BASE_CLASS_BRIDGE, sub_class, PROG_IF_NONE};
    wire [7:0] header_type = {1'b0, IS_ROOT_PORT ? LAYOUT_TYPE1 : LAYOUT_TYPE0};
    wire [15:0] pri_status = 16'h0001 << CAP_LIST_BIT;
    wire [7:0] io_base_rd = {io_base_q, IO_ADDR_CAP_16BIT};
    wire [7:0] io_limit_rd = {io_limit_q, IO_ADDR_CAP_16BIT};
    wire [15:0] sec_status_rd = {sec_sts_q[5:1], 2'b00, sec_sts_q[0], 8'h00};
    wire [7:0] unused_lane = 8'h00;
    wire unused_bits = ^{cfg_req.rd, sts_clr[0], wr_sts_lo};

    // Read mux; unmapped and legacy-only dwords read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (cfg_req.dw == dw_of(OFF_PRI_STATUS)) begin
            rd_mux = {pri_status, 16'h0000};
        end else if (cfg_req.dw == dw_of(OFF_REVISION)) begin
            rd_mux = {class_code, full_step, metal_step};
        end else if (cfg_req.dw == dw_of(OFF_CACHELINE)) begin
            rd_mux = {unused_lane, header_type, unused_lane, cacheline_q};
        end else if (cfg_req.dw == dw_of(OFF_PRI_BUS)) begin
            rd_mux = IS_ROOT_PORT ? {unused_lane, sub_bus_q, sec_bus_q, pri_bus_q}
                : 32'h0000_0000;
        end else if (cfg_req.dw == dw_of(OFF_IO_BASE)) begin
            rd_mux = IS_ROOT_PORT ? {sec_status_rd, io_limit_rd, io_base_rd}
                : 32'h0000_0000;
        end else if (cfg_req.dw == dw_of(OFF_SUBSYS_VENDOR)) begin
            rd_mux = {subsys_ident, subsys_vendor};
        end else if (cfg_req.dw == dw_of(OFF_CAP_POINTER)) begin
            rd_mux = {24'h000000, cap_pointer};
        end else if (cfg_req.dw == dw_of(OFF_INT_LINE)) begin
            rd_mux = {16'h0000, int_pin, int_line_q};
        end
    end

    // Read answer registered one cycle after the request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata_q <= 32'h0000_0000;
            cfg_rvalid_q <= 1'b0;
        end else begin
            cfg_rvalid_q <= cfg_req.rd;
            if (cfg_req.rd) cfg_rdata_q <= rd_mux;
        end
    end

    // Bus-number decode, inclusive bounds on the secondary range
    wire pri_hit = bus_query.valid && (bus_query.bus == pri_bus_q);
    wire cfg_in_range = IS_ROOT_PORT && bus_query.valid
        && (bus_query.bus >= sec_bus_q) && (bus_query.bus <= sub_bus_q);

    // I/O window in 1 KB units; coarse mode rounds base down and limit up
    wire [5:0] io_addr_kb = io_query.addr[15:10];
    wire [5:0] win_lo = one_kb_io_granularity ? io_base_q
        : {io_base_q[5:2], 2'b00};
    wire [5:0] win_hi = one_kb_io_granularity ? io_limit_q
        : {io_limit_q[5:2], 2'b11};
    wire win_open = (win_hi >= win_lo);
    // Decode honours the enable that software clears around reprogramming
    wire io_hit = IS_ROOT_PORT && io_query.valid && io_decode_enable && win_open
        && (io_addr_kb >= win_lo) && (io_addr_kb <= win_hi);

    // One-hot legacy interrupt; reserved codes select none
    wire [3:0] int_sel = (int_pin == INT_PIN_A) ? 4'h1
        : (int_pin == INT_PIN_B) ? 4'h2
        : (int_pin == INT_PIN_C) ? 4'h4
        : (int_pin == INT_PIN_D) ? 4'h8 : 4'h0;

    // Routing answers registered so every output leaves a flip-flop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            primary_bus_hit_q <= 1'b0;
            fwd_cfg_q <= 1'b0;
            fwd_io_q <= 1'b0;
            legacy_interrupt_select_q <= 4'h0;
        end else begin
            primary_bus_hit_q <= pri_hit;
            fwd_cfg_q <= cfg_in_range;
            fwd_io_q <= io_hit;
            legacy_interrupt_select_q <= int_sel | {3'b000, unused_bits & 1'b0};
        end
    end
endmodule : bridge_config_header
`default_nettype wire

// *** bridge_config_header_properties.sv ***
// Port-level checks for the bridge configuration header
`timescale 1ns/10ps
`default_nettype none
module bridge_config_header_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Configuration access
    input wire bridge_cfg_pkg::cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata_q,
    input wire logic cfg_rvalid_q,
    // Controls and events
    input wire logic host_bridge_mode,
    input wire logic io_decode_enable,
    input wire bridge_cfg_pkg::sec_evt_s sec_evt,
    // Queries and answers
    input wire bridge_cfg_pkg::bus_query_s bus_query,
    input wire bridge_cfg_pkg::io_query_s io_query,
    input wire logic primary_bus_hit_q,
    input wire logic fwd_cfg_q,
    input wire logic fwd_io_q,
    input wire logic [3:0] legacy_interrupt_select_q
);
    import bridge_cfg_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Read strobes per dword; identity checks assume the root-port layout
    wire rd_stat = cfg_req.rd && cfg_req.dw == 4'h1;
    wire rd_class = cfg_req.rd && cfg_req.dw == 4'h2;
    wire rd_hdr = cfg_req.rd && cfg_req.dw == 4'h3;
    wire rd_sec = cfg_req.rd && cfg_req.dw == 4'h7;

    read_answer_a: assert property (cfg_req.rd |=> cfg_rvalid_q)
        else $error("read not answered after one cycle");
    answer_cause_a: assert property (cfg_rvalid_q |-> $past(cfg_req.rd))
        else $error("read answer without a read");
    cap_present_a: assert property (rd_stat |=> cfg_rdata_q == 32'h0010_0000)
        else $error("primary status word wrong");
    class_code_a: assert property (rd_class |=> cfg_rdata_q[31:8] ==
        {BASE_CLASS_BRIDGE, $past(host_bridge_mode) ? SUB_CLASS_HOST : SUB_CLASS_P2P, PROG_IF_NONE})
        else $error("class code wrong");
    header_fixed_a: assert property (rd_hdr |=> cfg_rdata_q[23:8] == 16'h0100)
        else $error("header type or latency timer wrong");
    sec_fixed_a: assert property (rd_sec |=> cfg_rdata_q[26:25] == 2'h0
        && cfg_rdata_q[23:16] == 8'h0 && cfg_rdata_q[9:8] == 2'h0 && cfg_rdata_q[1:0] == 2'h0)
        else $error("fixed zero bits of dword 7 set");
    parity_seen_a: assert property (sec_evt.poisoned_tlp_rx ##1 !cfg_req.wr ##1 rd_sec
        |=> cfg_rdata_q[31])
        else $error("poisoned packet not recorded");
    io_gate_a: assert property (fwd_io_q |-> $past(io_decode_enable && io_query.valid))
        else $error("I/O forwarded without enabled query");
    cfg_gate_a: assert property ((fwd_cfg_q || primary_bus_hit_q) |-> $past(bus_query.valid))
        else $error("bus answer without query");
    pin_onehot_a: assert property ($onehot0(legacy_interrupt_select_q))
        else $error("interrupt select not one-hot");
endmodule : bridge_config_header_properties

bind bridge_config_header bridge_config_header_properties u_bridge_config_header_properties (
    .clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .host_bridge_mode(host_bridge_mode),
    .io_decode_enable(io_decode_enable), .sec_evt(sec_evt), .bus_query(bus_query),
    .io_query(io_query), .primary_bus_hit_q(primary_bus_hit_q), .fwd_cfg_q(fwd_cfg_q),
    .fwd_io_q(fwd_io_q), .legacy_interrupt_select_q(legacy_interrupt_select_q)
);
`default_nettype wire

// *** bridge_config_header_bench.sv ***
// Self-checking bench for the bridge configuration header
`timescale 1ns/10ps
`default_nettype none
module bridge_config_header_bench;
    import bridge_cfg_pkg::*;
    logic clk_sys, rst_b, host_bridge_mode, one_kb_io_granularity;
    logic parity_error_response_enable, io_decode_enable;
    logic primary_bus_hit_q, fwd_cfg_q, fwd_io_q, cfg_rvalid_q;
    logic [31:0] cfg_rdata_q;
    logic [3:0] legacy_interrupt_select_q;
    cfg_req_s cfg_req;
    sec_evt_s sec_evt;
    bus_query_s bus_query;
    io_query_s io_query;
    int num_errors = 0;
    int checks = 0;
    int pos[8] = '{8, 8, 11, 12, 13, 13, 14, 15};

    bridge_config_header u_bridge_config_header (
        .clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
        .cfg_rvalid_q(cfg_rvalid_q), .host_bridge_mode(host_bridge_mode),
        .one_kb_io_granularity(one_kb_io_granularity),
        .parity_error_response_enable(parity_error_response_enable),
        .io_decode_enable(io_decode_enable), .sec_evt(sec_evt), .bus_query(bus_query),
        .io_query(io_query), .primary_bus_hit_q(primary_bus_hit_q), .fwd_cfg_q(fwd_cfg_q),
        .fwd_io_q(fwd_io_q), .legacy_interrupt_select_q(legacy_interrupt_select_q)
    );

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // Reset held for 20 cycles
    task automatic do_reset();
        @(posedge clk_sys);
        #1;
        rst_b = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
    endtask : do_reset

    // One access and event cycle
    task automatic op(input logic w, input logic [3:0] dw, input logic [3:0] be,
                      input logic [31:0] d, input logic [7:0] e);
        @(posedge clk_sys);
        #1;
        cfg_req = {w, 1'b0, dw, be, d};
        sec_evt = e;
        @(posedge clk_sys);
        #1;
        cfg_req = '0;
        sec_evt = '0;
    endtask : op

    task automatic wr(input logic [3:0] dw, input logic [3:0] be, input logic [31:0] d);
        op(1'b1, dw, be, d, 8'h00);
    endtask : wr

    // Read a dword; answer lands exactly one edge later
    task automatic rd(input logic [3:0] dw, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk_sys);
        #1;
        cfg_req = {1'b0, 1'b1, dw, 4'h0, 32'h0};
        @(posedge clk_sys);
        #1;
        cfg_req = '0;
        chk({31'h0, cfg_rvalid_q}, 32'h1);
        chk(cfg_rdata_q & m, exp);
    endtask : rd

    // Routing query; answer is {fwd_cfg, primary_hit, fwd_io} one edge later
    task automatic qry(input logic bq, input logic [15:0] v, input logic [2:0] exp);
        @(posedge clk_sys);
        #1;
        if (bq) bus_query = {1'b1, v[7:0]};
        else io_query = {1'b1, v};
        @(posedge clk_sys);
        #1;
        bus_query = '0;
        io_query = '0;
        chk({29'h0, fwd_cfg_q, primary_bus_hit_q, fwd_io_q}, {29'h0, exp});
    endtask : qry

    // Hang guard, well above the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        cfg_req = '0;
        sec_evt = '0;
        bus_query = '0;
        io_query = '0;
        host_bridge_mode = 1'b0;
        one_kb_io_granularity = 1'b0;
        parity_error_response_enable = 1'b1;
        io_decode_enable = 1'b0;
        do_reset();
        // Reset values, fixed fields and an unmapped dword
        rd(4'h1, 32'hFFFF_FFFF, 32'h0010_0000);
        rd(4'h2, 32'hFFFF_FFFF, 32'h0604_0000);
        rd(4'h3, 32'h00FF_FFFF, 32'h0001_0000);
        rd(4'h6, 32'h00FF_FFFF, 32'h0);
        rd(4'h7, 32'hFFFF_FFFF, 32'h0);
        rd(4'hB, 32'hFFFF_FFFF, 32'h0000_1234);
        rd(4'hD, 32'h0000_00FF, 32'h40);
        rd(4'hF, 32'h0000_FFFF, 32'h0100);
        chk({28'h0, legacy_interrupt_select_q}, 32'h1);
        wr(4'h4, 4'hF, 32'hFFFF_FFFF);
        rd(4'h4, 32'hFFFF_FFFF, 32'h0);
        host_bridge_mode = 1'b1;
        rd(4'h2, 32'hFFFF_FF00, 32'h0600_0000);
        host_bridge_mode = 1'b0;
        $display("test reset_values done");
        // Write-once fields take the first write only
        wr(4'h2, 4'hF, 32'hFFFF_FF5A);
        wr(4'h2, 4'h1, 32'h0000_00A5);
        rd(4'h2, 32'hFFFF_FFFF, 32'h0604_005A);
        wr(4'hB, 4'h3, 32'h0000_BEEF);
        wr(4'hB, 4'hC, 32'h1357_0000);
        wr(4'hB, 4'hF, 32'h0);
        rd(4'hB, 32'hFFFF_FFFF, 32'h1357_BEEF);
        wr(4'hD, 4'h1, 32'h50);
        wr(4'hD, 4'h1, 32'h60);
        rd(4'hD, 32'h0000_00FF, 32'h50);
        wr(4'h3, 4'hF, 32'hFFFF_FF7F);
        rd(4'h3, 32'h00FF_FFFF, 32'h0001_007F);
        wr(4'hF, 4'h3, 32'h0377);
        wr(4'hF, 4'h3, 32'h0122);
        rd(4'hF, 32'h0000_FFFF, 32'h0322);
        chk({28'h0, legacy_interrupt_select_q}, 32'h4);
        $display("test write_once done");
        // Bus number decode, both bounds inclusive
        wr(4'h6, 4'h7, 32'h0030_2005);
        rd(4'h6, 32'h00FF_FFFF, 32'h0030_2005);
        qry(1'b1, 16'h1F, 3'h0);
        qry(1'b1, 16'h20, 3'h4);
        qry(1'b1, 16'h30, 3'h4);
        qry(1'b1, 16'h31, 3'h0);
        qry(1'b1, 16'h05, 3'h2);
        $display("test bus_decode done");
        // I/O window, 4 KB then 1 KB granularity; decode off while reprogramming
        wr(4'h7, 4'h3, 32'h3C2F);
        rd(4'h7, 32'h0000_FFFF, 32'h3020);
        io_decode_enable = 1'b1;
        qry(1'b0, 16'h1FFF, 3'h0);
        qry(1'b0, 16'h2000, 3'h1);
        qry(1'b0, 16'h3FFF, 3'h1);
        qry(1'b0, 16'h4000, 3'h0);
        io_decode_enable = 1'b0;
        qry(1'b0, 16'h2000, 3'h0);
        one_kb_io_granularity = 1'b1;
        wr(4'h7, 4'h3, 32'h2824);
        rd(4'h7, 32'h0000_FFFF, 32'h2824);
        io_decode_enable = 1'b1;
        qry(1'b0, 16'h23FF, 3'h0);
        qry(1'b0, 16'h2400, 3'h1);
        qry(1'b0, 16'h2BFF, 3'h1);
        qry(1'b0, 16'h2C00, 3'h0);
        io_decode_enable = 1'b0;
        wr(4'h7, 4'h3, 32'h2030);
        io_decode_enable = 1'b1;
        qry(1'b0, 16'h3000, 3'h0);
        qry(1'b0, 16'h2000, 3'h0);
        $display("test io_window done");
        // Each event sets its bit; zero writes keep it, one writes clear it
        for (int k = 0; k < 8; k++) begin
            op(1'b0, 4'h0, 4'h0, 32'h0, 8'h01 << k);
            rd(4'h7, 32'hFFFF_0000, 32'h1 << (16 + pos[k]));
            wr(4'h7, 4'hC, 32'h0);
            rd(4'h7, 32'hFFFF_0000, 32'h1 << (16 + pos[k]));
            wr(4'h7, 4'hC, 32'hFFFF_0000);
            rd(4'h7, 32'hFFFF_0000, 32'h0);
        end
        parity_error_response_enable = 1'b0;
        op(1'b0, 4'h0, 4'h0, 32'h0, 8'h03);
        rd(4'h7, 32'hFFFF_0000, 32'h0);
        op(1'b1, 4'h7, 4'hC, 32'hFFFF_0000, 8'h80);
        rd(4'h7, 32'hFFFF_0000, 32'h8000_0000);
        $display("test sec_status done");
        // Interrupt pin codes 1 to 5, A-D and one reserved, a fresh reset for each
        for (int i = 1; i < 6; i++) begin
            do_reset();
            wr(4'hF, 4'h2, {16'h0, 8'(i), 8'h00});
            @(posedge clk_sys);
            #1;
            chk({28'h0, legacy_interrupt_select_q}, (i < 5) ? 32'h1 << (i - 1) : 32'h0);
        end
        $display("test pin_codes done");
        close_out();
    end
endmodule : bridge_config_header_bench
`default_nettype wire
